// >>> logic/oset_pkg.sv
/*
  Constants and types shared by the operation status event tree.
  Assumes a single clock domain and a command port driven by the remote-command parser.
*/
`default_nettype none

package oset_pkg;

  localparam int OSET_W = 16;

  // Power-up contents of the programmable masks
  localparam logic [15:0] OSET_RISE_RST = 16'hffff;
  localparam logic [15:0] OSET_FALL_RST = 16'h0000;
  localparam logic [15:0] OSET_ENA_RST = 16'h0000;
  localparam logic [15:0] OSET_ZERO = 16'h0000;

  // Field positions
  localparam int OSET_OPER_BB_BIT = 10;
  localparam int OSET_BB_ACTIVE_BIT = 0;
  localparam int OSET_BB_IO_BIT = 1;

  // Register selector carried with every command
  typedef enum logic [3:0] {
    OSET_SEL_OPER_COND = 4'h0,
    OSET_SEL_OPER_RISE = 4'h1,
    OSET_SEL_OPER_FALL = 4'h2,
    OSET_SEL_OPER_EVT = 4'h3,
    OSET_SEL_OPER_ENA = 4'h4,
    OSET_SEL_BB_COND = 4'h5,
    OSET_SEL_BB_RISE = 4'h6,
    OSET_SEL_BB_FALL = 4'h7,
    OSET_SEL_BB_EVT = 4'h8,
    OSET_SEL_BB_ENA = 4'h9
  } oset_sel_t;

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] ena;
    logic [15:0] evt;
  } oset_grp_t;

  localparam oset_grp_t OSET_GRP_RST = '{
    prev: OSET_ZERO, rise: OSET_RISE_RST, fall: OSET_FALL_RST, ena: OSET_ENA_RST,
    evt: OSET_ZERO};

  typedef struct packed {
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic stb7;
  } oset_top_t;

  localparam oset_top_t OSET_TOP_RST = '{rsp_valid: 1'b0, rsp_data: OSET_ZERO, stb7: 1'b0};

endpackage : oset_pkg

`default_nettype wire

// >>> logic/oset_group.sv
/*
  One status group: transition filters, latching event register, enable mask, summary.
  Assumes write and read strobes are one-cycle pulses from the owning command decoder.
*/
`timescale 1ns/100ps
`default_nettype none

module oset_group (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] cond,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire logic wr_ena,
  input wire logic [15:0] wdata,
  input wire logic rd_evt,
  output logic [15:0] rise_filter,
  output logic [15:0] fall_filter,
  output logic [15:0] ena_mask,
  output logic [15:0] evt,
  output logic summary
);
  import oset_pkg::*;

  oset_grp_t s_r;
  oset_grp_t s_nxt;
  logic [15:0] rose;
  logic [15:0] fell;

  assign rose = cond & ~s_r.prev;
  assign fell = ~cond & s_r.prev;

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = cond;
    if (wr_rise) begin
      s_nxt.rise = wdata;
    end
    if (wr_fall) begin
      s_nxt.fall = wdata;
    end
    if (wr_ena) begin
      s_nxt.ena = wdata;
    end
    // Clear on read, but a transition in the same cycle still lands
    s_nxt.evt = (rd_evt ? OSET_ZERO : s_r.evt)
      | (rose & s_r.rise)
      | (fell & s_r.fall);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= OSET_GRP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise_filter = s_r.rise;
  assign fall_filter = s_r.fall;
  assign ena_mask = s_r.ena;
  assign evt = s_r.evt;
  assign summary = |(s_r.evt & s_r.ena);

  rise_capture_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 ((evt & $past(rose & s_r.rise)) == $past(rose & s_r.rise)))
    else $error("filtered rising edge not latched");

  fall_capture_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 ((evt & $past(fell & s_r.fall)) == $past(fell & s_r.fall)))
    else $error("filtered falling edge not latched");

  event_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !rd_evt |=> ((evt & $past(evt)) == $past(evt)))
    else $error("event bit lost without a read");

  event_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    rd_evt |=> (evt == $past((rose & s_r.rise) | (fell & s_r.fall))))
    else $error("event register not cleared by read");

  mask_store_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_ena |=> (ena_mask == $past(wdata)) ##1 (ena_mask == $past(ena_mask) || $past(wr_ena)))
    else $error("enable mask not stored");

  unfiltered_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 ((evt & ~$past(evt) & ~$past((rose & s_r.rise) | (fell & s_r.fall))) == OSET_ZERO))
    else $error("event set without a filtered transition");

endmodule : oset_group

`default_nettype wire

// >>> logic/oset_top.sv
/*
  Operation status event tree: operation group plus baseband sub-group, command decode,
  registered query answers and the status byte bit 7 summary.
  Assumes one command per cycle at most from the remote-command parser, all inputs
  synchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none

module oset_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire oset_pkg::oset_sel_t cmd_sel,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] oper_cond_live,
  input wire logic bb_active,
  input wire logic bb_io_busy,
  input wire logic bb_present,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic status_byte_bit7
);
  import oset_pkg::*;

  oset_top_t s_r;
  oset_top_t s_nxt;

  logic [15:0] oper_cond;
  logic [15:0] bb_cond;
  logic [15:0] oper_rise;
  logic [15:0] oper_fall;
  logic [15:0] oper_ena;
  logic [15:0] oper_evt;
  logic oper_sum;
  logic [15:0] bb_rise;
  logic [15:0] bb_fall;
  logic [15:0] bb_ena;
  logic [15:0] bb_evt;
  logic bb_sum;

  // True for a command of the given direction aimed at the given register
  function automatic logic oset_hit(input logic valid, input logic wr, input logic want_wr,
                                    input oset_sel_t sel, input oset_sel_t target);
    oset_hit = valid && (wr == want_wr) && (sel == target);
  endfunction : oset_hit

  // Baseband condition: live bits 0 and 1, all else zero, nothing without the generator
  always_comb begin
    bb_cond = OSET_ZERO;
    if (bb_present) begin
      bb_cond[OSET_BB_ACTIVE_BIT] = bb_active;
      bb_cond[OSET_BB_IO_BIT] = bb_io_busy;
    end
  end

  // Operation condition: live inputs with bit 10 taken from the baseband summary
  always_comb begin
    oper_cond = oper_cond_live;
    oper_cond[OSET_OPER_BB_BIT] = bb_sum;
  end

  oset_group u_bb (
    .clock(clock),
    .sys_rst(sys_rst),
    .cond(bb_cond),
    .wr_rise(oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_BB_RISE)),
    .wr_fall(oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_BB_FALL)),
    .wr_ena(oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_BB_ENA)),
    .wdata(cmd_wdata),
    .rd_evt(oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_BB_EVT)),
    .rise_filter(bb_rise),
    .fall_filter(bb_fall),
    .ena_mask(bb_ena),
    .evt(bb_evt),
    .summary(bb_sum)
  );

  oset_group u_oper (
    .clock(clock),
    .sys_rst(sys_rst),
    .cond(oper_cond),
    .wr_rise(oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_RISE)),
    .wr_fall(oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_FALL)),
    .wr_ena(oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_ENA)),
    .wdata(cmd_wdata),
    .rd_evt(oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_OPER_EVT)),
    .rise_filter(oper_rise),
    .fall_filter(oper_fall),
    .ena_mask(oper_ena),
    .evt(oper_evt),
    .summary(oper_sum)
  );

  // Query mux and status byte summary
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = cmd_valid && !cmd_write;
    s_nxt.stb7 = oper_sum;
    if (cmd_valid && !cmd_write) begin
      unique case (cmd_sel)
        OSET_SEL_OPER_COND: s_nxt.rsp_data = oper_cond;
        OSET_SEL_OPER_RISE: s_nxt.rsp_data = oper_rise;
        OSET_SEL_OPER_FALL: s_nxt.rsp_data = oper_fall;
        OSET_SEL_OPER_EVT: s_nxt.rsp_data = oper_evt;
        OSET_SEL_OPER_ENA: s_nxt.rsp_data = oper_ena;
        OSET_SEL_BB_COND: s_nxt.rsp_data = bb_cond;
        OSET_SEL_BB_RISE: s_nxt.rsp_data = bb_present ? bb_rise : OSET_ZERO;
        OSET_SEL_BB_FALL: s_nxt.rsp_data = bb_present ? bb_fall : OSET_ZERO;
        OSET_SEL_BB_EVT: s_nxt.rsp_data = bb_present ? bb_evt : OSET_ZERO;
        OSET_SEL_BB_ENA: s_nxt.rsp_data = bb_present ? bb_ena : OSET_ZERO;
        default: s_nxt.rsp_data = OSET_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= OSET_TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp_valid = s_r.rsp_valid;
  assign rsp_data = s_r.rsp_data;
  assign status_byte_bit7 = s_r.stb7;

  status_bit7_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 (status_byte_bit7 == $past(|(oper_evt & oper_ena))))
    else $error("status byte bit 7 does not follow enabled operation events");

  bb_to_oper_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_OPER_COND)
    |=> (rsp_data[OSET_OPER_BB_BIT] == $past(|(bb_evt & bb_ena))))
    else $error("operation bit 10 does not follow the baseband summary");

  bb_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
    (bb_ena == OSET_ZERO) |-> !oper_cond[OSET_OPER_BB_BIT])
    else $error("masked baseband events reach the operation group");

  bb_active_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_BB_COND) && bb_present
    |=> rsp_valid && (rsp_data[OSET_BB_ACTIVE_BIT] == $past(bb_active)))
    else $error("baseband active bit wrong in query");

  bb_io_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_BB_COND) && bb_present
    |=> (rsp_data[OSET_BB_IO_BIT] == $past(bb_io_busy)))
    else $error("baseband io bit wrong in query");

  bb_unused_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_BB_COND)
    |=> (rsp_data[15:2] == 14'h0000))
    else $error("unused baseband condition bits read as one");

  cond_live_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_OPER_COND)
    |=> rsp_valid && (rsp_data == $past(oper_cond)))
    else $error("operation condition query does not return live state");

  bb_absent_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_valid && !cmd_write && !bb_present && (cmd_sel >= OSET_SEL_BB_COND)
    |=> rsp_valid && (rsp_data == OSET_ZERO))
    else $error("baseband query nonzero on a variant without baseband");

  no_write_rsp_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_valid && cmd_write |=> !rsp_valid)
    else $error("write produced a response");

  evt_readonly_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_EVT)
    |=> ((oper_evt & ~$past(oper_evt)) == OSET_ZERO) || $past(oper_cond != u_oper.s_r.prev))
    else $error("event register changed by a host write");

  mask_echo_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_RISE)
    ##1 oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_OPER_RISE)
    |=> (rsp_data == $past(cmd_wdata, 2)))
    else $error("rising filter does not echo the written value");

  // A summary that lagged by a cycle would delay the operation event by one more
  bb_sum_comb_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(|(bb_evt & bb_ena)) && oper_rise[OSET_OPER_BB_BIT]
    |=> oper_evt[OSET_OPER_BB_BIT])
    else $error("baseband summary lags its inputs");

  query_answer_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_valid && !cmd_write |=> rsp_valid)
    else $error("query without an answer");

  fall_echo_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_FALL)
    ##1 oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_OPER_FALL)
    |=> (rsp_data == $past(cmd_wdata, 2)))
    else $error("falling filter does not echo the written value");

  ena_echo_a: assert property (@(posedge clock) disable iff (sys_rst)
    oset_hit(cmd_valid, cmd_write, 1'b1, cmd_sel, OSET_SEL_OPER_ENA)
    ##1 oset_hit(cmd_valid, cmd_write, 1'b0, cmd_sel, OSET_SEL_OPER_ENA)
    |=> (rsp_data == $past(cmd_wdata, 2)))
    else $error("enable mask does not echo the written value");

endmodule : oset_top

`default_nettype wire

// >>> bench/oset_top_tb_top.sv
/*
  Self-checking testbench for the operation status event tree top module.
  Assumes the design package and the top module are compiled first; single clock.
*/
`timescale 1ns/100ps
`default_nettype none

module oset_top_tb_top;
  import oset_pkg::*;

  logic clock;
  logic sys_rst;
  logic cmd_valid;
  logic cmd_write;
  oset_sel_t cmd_sel;
  logic [15:0] cmd_wdata;
  logic [15:0] oper_cond_live;
  logic bb_active;
  logic bb_io_busy;
  logic bb_present;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic status_byte_bit7;
  logic [15:0] exp_q[$];
  logic [15:0] op_ena;
  logic [15:0] v;
  int bad_count;
  int comparisons;
  oset_sel_t wsel[6] = '{OSET_SEL_OPER_RISE, OSET_SEL_OPER_FALL, OSET_SEL_OPER_ENA,
                         OSET_SEL_BB_RISE, OSET_SEL_BB_FALL, OSET_SEL_BB_ENA};

  oset_top i_oset_top (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .oper_cond_live(oper_cond_live), .bb_active(bb_active), .bb_io_busy(bb_io_busy),
    .bb_present(bb_present), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .status_byte_bit7(status_byte_bit7));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Answer watcher: every answer is matched against the oldest pending note
  always @(negedge clock) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("BAD rsp_valid expected 0 seen 1");
      end else begin
        chk("rsp_data", exp_q.pop_front(), rsp_data);
      end
    end
  end

  // Idle cycles: the command strobe drops here, so back-to-back commands keep it high
  task automatic step(input int n);
    cmd_valid = 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic cmd(input logic w, input oset_sel_t sel, input logic [15:0] d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = sel;
    cmd_wdata = d;
    @(posedge clock);
    #1;
  endtask : cmd

  task automatic wr(input oset_sel_t sel, input logic [15:0] d);
    cmd(1'b1, sel, d);
  endtask : wr

  task automatic rd(input oset_sel_t sel, input logic [15:0] exp);
    exp_q.push_back(exp);
    cmd(1'b0, sel, 16'($urandom()));
  endtask : rd

  task automatic drain();
    int n;
    n = 0;
    step(1);
    while (exp_q.size() != 0 && n < 8) begin
      step(1);
      n++;
    end
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("BAD pending answers expected 0 seen %0d", exp_q.size());
      final_report();
    end
  endtask : drain

  // Moves the live condition to b (and back to a when asked), then reads the event twice
  task automatic trans(input logic [15:0] b, input logic [15:0] r, input logic [15:0] f,
                       input bit back);
    logic [15:0] a;
    logic [15:0] e;
    a = oper_cond_live;
    e = ((~a & b & r) | (a & ~b & f)) & 16'hfbff;
    if (back) e = e | (((a & ~b & r) | (~a & b & f)) & 16'hfbff);
    wr(OSET_SEL_OPER_RISE, r);
    wr(OSET_SEL_OPER_FALL, f);
    oper_cond_live = b;
    step(3);
    if (back) begin
      oper_cond_live = a;
      step(3);
    end
    chk("status_byte_bit7", {15'h0000, |(e & op_ena)}, {15'h0000, status_byte_bit7});
    rd(OSET_SEL_OPER_EVT, e);
    rd(OSET_SEL_OPER_EVT, 16'h0000);
    rd(OSET_SEL_OPER_COND, oper_cond_live & 16'hfbff);
    drain();
  endtask : trans

  initial begin
    sys_rst = 1'b1;
    cmd_write = 1'b0;
    cmd_sel = OSET_SEL_OPER_COND;
    cmd_wdata = 16'h0000;
    oper_cond_live = 16'h0000;
    bb_active = 1'b0;
    bb_io_busy = 1'b0;
    bb_present = 1'b1;
    v = 16'($urandom(23543));
    step(6);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(oset_sel_t'(i[3:0]), (i == 1 || i == 6) ? 16'hffff : 16'h0000);
    end
    drain();
    $display("test reset values done");
    foreach (wsel[k]) begin
      v = 16'($urandom());
      wr(wsel[k], v);
      rd(wsel[k], v);
    end
    wr(OSET_SEL_OPER_EVT, 16'hffff);
    rd(OSET_SEL_OPER_EVT, 16'h0000);
    wr(OSET_SEL_BB_COND, 16'hffff);
    rd(OSET_SEL_BB_COND, 16'h0000);
    wr(oset_sel_t'(4'hc), 16'hffff);
    rd(oset_sel_t'(4'hc), 16'h0000);
    op_ena = 16'($urandom());
    wr(OSET_SEL_OPER_ENA, op_ena);
    drain();
    $display("test register access done");
    for (int k = 0; k < 8; k++) begin
      trans(16'($urandom()), 16'($urandom()), 16'($urandom()), k[0]);
    end
    trans(16'($urandom()), 16'hffff, 16'h0000, 1'b1);
    $display("test transitions done");
    wr(OSET_SEL_BB_RISE, 16'h0001);
    wr(OSET_SEL_BB_FALL, 16'h0002);
    wr(OSET_SEL_BB_ENA, 16'h0001);
    wr(OSET_SEL_OPER_RISE, 16'h0400);
    wr(OSET_SEL_OPER_FALL, 16'h0000);
    op_ena = 16'h0400;
    wr(OSET_SEL_OPER_ENA, op_ena);
    bb_active = 1'b1;
    step(4);
    rd(OSET_SEL_BB_COND, 16'h0001);
    chk("status_byte_bit7", 16'h0001, {15'h0000, status_byte_bit7});
    rd(OSET_SEL_OPER_COND, (oper_cond_live & 16'hfbff) | 16'h0400);
    wr(OSET_SEL_BB_ENA, 16'h0000);
    step(1);
    rd(OSET_SEL_OPER_COND, oper_cond_live & 16'hfbff);
    rd(OSET_SEL_OPER_EVT, 16'h0400);
    step(3);
    chk("status_byte_bit7", 16'h0000, {15'h0000, status_byte_bit7});
    bb_io_busy = 1'b1;
    step(3);
    rd(OSET_SEL_BB_COND, 16'h0003);
    rd(OSET_SEL_BB_EVT, 16'h0001);
    bb_io_busy = 1'b0;
    step(3);
    rd(OSET_SEL_BB_EVT, 16'h0002);
    drain();
    $display("test baseband group done");
    bb_present = 1'b0;
    step(1);
    for (int i = 5; i < 10; i++) begin
      rd(oset_sel_t'(i[3:0]), 16'h0000);
    end
    drain();
    $display("test missing baseband done");
    final_report();
  end
endmodule : oset_top_tb_top

`default_nettype wire
